// *** hw/snl_loader.sv ***
// design: two serial ports that load oscillator frequency words
// =====================================================
// top: two identical ports sharing one width select
// Overview of operation
// R1 - two independent ports with identical loading, one per oscillator.
// R2 - the carrier offset pins load the carrier offset frequency word for the mixer oscillator.
// R3 - the sample offset pins load the sample offset frequency word for the resampler oscillator.
// R4 - words arrive and are assembled most significant bit first.
// R5 - word length is selectable as 8, 16, 24 or 32 bits, exactly that many bits per word.
// R6 - pins are sampled on rising edges and sync is high the cycle before the first bit.
// R7 - after sync the width is counted down, then the word is copied to the holding register and the port rearms.
// R8 - shorter words are left justified in the holding register with low bits cleared.
// R9 - the sender holds each sync high for one cycle only.
// R10 - the word length comes from one shared input, held steady during reception.
module snl_loader
   import snl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] width_sel,
   input wire logic carrier_offset_serial_in,
   input wire logic carrier_offset_word_sync,
   input wire logic sample_offset_serial_in,
   input wire logic sample_offset_word_sync,
   output logic [SNL_HOLD_W-1:0] carrier_offset_freq,
   output logic carrier_offset_load,
   output logic [SNL_HOLD_W-1:0] sample_offset_freq,
   output logic sample_offset_load
);

   // pin pairs bundled per port, words come back out of flops
   snl_serial_t cof_ser;
   snl_serial_t sof_ser;
   snl_word_t cof_word;
   snl_word_t sof_word;

   // R10 - one shared width select drives both ports
   assign cof_ser = '{data: carrier_offset_serial_in, sync: carrier_offset_word_sync};
   assign sof_ser = '{data: sample_offset_serial_in, sync: sample_offset_word_sync};

   // R1 - R2 - carrier offset port for the mixer oscillator
   snl_port u_carrier (
      .sys_clk(sys_clk),
      .rst(rst),
      .width_sel(width_sel),
      .ser(cof_ser),
      .hold(cof_word)
   );

   // R1 - R3 - sample offset port for the resampler oscillator
   snl_port u_sample (
      .sys_clk(sys_clk),
      .rst(rst),
      .width_sel(width_sel),
      .ser(sof_ser),
      .hold(sof_word)
   );

   // port outputs are flops already, so these are plain wires
   assign carrier_offset_freq = cof_word.word;
   assign carrier_offset_load = cof_word.load;
   assign sample_offset_freq = sof_word.word;
   assign sample_offset_load = sof_word.load;

endmodule : snl_loader

// =====================================================
// serial port engine, one instance per oscillator
module snl_port
   import snl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] width_sel,
   input wire snl_serial_t ser,
   output snl_word_t hold
);

   logic [SNL_CNT_W-1:0] count_r;
   logic [SNL_HOLD_W-1:0] shift_r;
   logic [SNL_HOLD_W-1:0] hold_r;
   logic load_r;
   logic [SNL_CNT_W-1:0] len;
   logic [SNL_HOLD_W-1:0] shift_nxt;
   logic last_bit;

   // R5 - width select to bit count
   // only four lengths exist, so every select code is legal
   always_comb begin
      unique case (width_sel)
         SNL_WSEL_8: len = SNL_LEN_8;
         SNL_WSEL_16: len = SNL_LEN_16;
         SNL_WSEL_24: len = SNL_LEN_24;
         SNL_WSEL_32: len = SNL_LEN_32;
      endcase
   end

   // R4 - msb first shift
   assign shift_nxt = {shift_r[SNL_HOLD_W-2:0], ser.data};
   assign last_bit = (count_r == 6'h01);

   // R6 - sync one cycle ahead of the first bit arms the down count
   // R7 - counting down the programmed width
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         count_r <= SNL_CNT_RST;
      end else if (ser.sync) begin
         count_r <= len;  // a new sync restarts even a word in progress
      end else if (count_r != SNL_CNT_RST) begin
         count_r <= count_r - 6'h01;
      end
   end

   // shifting stops when the count is spent, so idle bits are ignored
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         shift_r <= SNL_HOLD_RST;
      end else if (count_r != SNL_CNT_RST) begin
         shift_r <= shift_nxt;
      end
   end

   // R7 - copy to holding register on the last bit
   // R8 - short words left justified, low bits cleared
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hold_r <= SNL_HOLD_RST;
         load_r <= 1'b0;
      end else begin
         load_r <= (count_r != SNL_CNT_RST) && last_bit && !ser.sync;
         if ((count_r != SNL_CNT_RST) && last_bit && !ser.sync) begin
            unique case (width_sel)
               SNL_WSEL_8: hold_r <= {shift_nxt[7:0], 24'h00_0000};
               SNL_WSEL_16: hold_r <= {shift_nxt[15:0], 16'h0000};
               SNL_WSEL_24: hold_r <= {shift_nxt[23:0], 8'h00};
               SNL_WSEL_32: hold_r <= shift_nxt;
            endcase
         end
      end
   end

   assign hold.word = hold_r;
   assign hold.load = load_r;

   // =====================================================
   // checks
   // R7 - load follows sync by exactly width plus one edges for 8 bit words
   load_time_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
      (ser.sync && width_sel == SNL_WSEL_8) ##1 (!ser.sync && width_sel == SNL_WSEL_8) [*8]
      |=> hold.load)
      else $error("8 bit word not loaded on time");
   // R8 - short words leave low byte zero
   low_zero_a: assert property (@(posedge sys_clk) disable iff (rst) // R8
      (hold.load && $past(width_sel) != SNL_WSEL_32) |-> hold.word[7:0] == 8'h00)
      else $error("low bits of short word not cleared");
   // word value checks use 8 bit words so every delay stays short
   // R4 - first bit after sync lands in the msb of an 8 bit word
   msb_first_a: assert property (@(posedge sys_clk) disable iff (rst) // R4
      (ser.sync && width_sel == SNL_WSEL_8) ##1 (!ser.sync && width_sel == SNL_WSEL_8) [*8]
      |=> hold.word[31] == $past(ser.data, 8))
      else $error("first bit of 8 bit word not in msb");

   // R4 - last bit of an 8 bit word lands just above the cleared bits
   lsb_last_a: assert property (@(posedge sys_clk) disable iff (rst) // R4
      (ser.sync && width_sel == SNL_WSEL_8) ##1 (!ser.sync && width_sel == SNL_WSEL_8) [*8]
      |=> hold.word[24] == $past(ser.data, 1))
      else $error("last bit of 8 bit word misplaced");

   // R8 - 16 bit words leave the low half zero
   half_zero_a: assert property (@(posedge sys_clk) disable iff (rst) // R8
      (hold.load && $past(width_sel) == SNL_WSEL_16) |-> hold.word[15:0] == 16'h0000)
      else $error("low half of 16 bit word not cleared");

   // R8 - 8 bit words leave the low three bytes zero
   byte_zero_a: assert property (@(posedge sys_clk) disable iff (rst) // R8
      (hold.load && $past(width_sel) == SNL_WSEL_8) |-> hold.word[23:0] == 24'h00_0000)
      else $error("low bytes of 8 bit word not cleared");

   // R5 - the shortest select arms exactly eight bits
   len_eight_a: assert property (@(posedge sys_clk) disable iff (rst) // R5
      (ser.sync && width_sel == SNL_WSEL_8) |=> count_r == SNL_LEN_8)
      else $error("8 bit select armed a wrong count");

   // R5 - the full select arms exactly thirty two bits
   len_full_a: assert property (@(posedge sys_clk) disable iff (rst) // R5
      (ser.sync && width_sel == SNL_WSEL_32) |=> count_r == SNL_LEN_32)
      else $error("32 bit select armed a wrong count");

   // R7 - the load is a single cycle pulse, the shortest word is eight bits
   load_pulse_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
      hold.load |=> !hold.load)
      else $error("load pulse longer than one cycle");

   // R7 - an idle port never loads, so junk between words cannot leak
   idle_no_load_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
      count_r == SNL_CNT_RST |=> !hold.load)
      else $error("load from an idle port");

   // R7 - the count steps down by one per bit while no sync arrives
   count_step_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
      (count_r != SNL_CNT_RST && !ser.sync) |=> count_r == $past(count_r) - 6'h01)
      else $error("bit count did not step down");

   // R7 - shifting stops once the count is spent
   shift_still_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
      count_r == SNL_CNT_RST |=> $stable(shift_r))
      else $error("shift register moved while idle");

   // R6 - a sync on the last bit edge restarts the port and drops that word
   restart_drop_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
      (ser.sync && last_bit) |=> !hold.load)
      else $error("cut word was loaded");

   // R6 - count armed the cycle after sync
   sync_arm_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
      ser.sync |=> count_r == $past(len))
      else $error("sync did not arm the count");
   // R5 - count never exceeds thirty two
   count_max_a: assert property (@(posedge sys_clk) disable iff (rst) // R5
      count_r <= SNL_LEN_32)
      else $error("bit count out of range");
   // R7 - hold word changes only with a load
   hold_still_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
      !hold.load |-> $stable(hold.word))
      else $error("holding register changed without a load");
   // R7 - after a load the port is idle and accepts a new sync
   load_idle_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
      hold.load && !$past(ser.sync) |-> count_r == SNL_CNT_RST || $past(ser.sync))
      else $error("port not idle after load");

endmodule : snl_port

// *** hw/snl_pkg.sv ***
// package: constants and carrier types for the serial frequency word loaders
package snl_pkg;

   // =====================================================
   // word width and width select encoding
   localparam int unsigned SNL_HOLD_W = 32;
   localparam int unsigned SNL_CNT_W = 6;
   localparam logic [1:0] SNL_WSEL_8 = 2'h0;
   localparam logic [1:0] SNL_WSEL_16 = 2'h1;
   localparam logic [1:0] SNL_WSEL_24 = 2'h2;
   localparam logic [1:0] SNL_WSEL_32 = 2'h3;
   localparam logic [SNL_CNT_W-1:0] SNL_LEN_8 = 6'h08;
   localparam logic [SNL_CNT_W-1:0] SNL_LEN_16 = 6'h10;
   localparam logic [SNL_CNT_W-1:0] SNL_LEN_24 = 6'h18;
   localparam logic [SNL_CNT_W-1:0] SNL_LEN_32 = 6'h20;

   // =====================================================
   // reset values
   localparam logic [SNL_HOLD_W-1:0] SNL_HOLD_RST = 32'h0000_0000;
   localparam logic [SNL_CNT_W-1:0] SNL_CNT_RST = 6'h00;

   // serial pin pair from the tracking loop
   typedef struct packed {
      logic data;
      logic sync;
   } snl_serial_t;

   // loaded word towards an oscillator
   typedef struct packed {
      logic [SNL_HOLD_W-1:0] word;
      logic load;
   } snl_word_t;

endpackage : snl_pkg

// *** verif/snl_track_loop.sv ***
// partner model: tracking loop that shifts frequency words into one serial port
module snl_track_loop (
   input wire logic sys_clk,
   output logic ser_data,
   output logic ser_sync
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle pins at time zero
   initial begin
      ser_data = 1'b0;
      ser_sync = 1'b0;
   end

   // ==========================================
   // word sender
   // one-cycle sync, then msb first
   task automatic send(input logic [31:0] w, input int n);
      @(negedge sys_clk);
      ser_sync = 1'b1;
      ser_data = ~ser_data; // junk in the sync cycle must be ignored
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge sys_clk);
         ser_sync = 1'b0;
         ser_data = w[i];
      end
   endtask : send
endmodule : snl_track_loop

// *** verif/tb_top.sv ***
// testbench: both serial frequency ports against the tracking loop model
module tb_top
   import snl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst, co_d, co_s, so_d, so_s, co_ld, so_ld;
   logic [1:0] width_sel;
   logic [SNL_HOLD_W-1:0] co_f, so_f;
   int miscompares, n_tests, co_cnt, so_cnt;

   snl_loader i_dut (.sys_clk(sys_clk), .rst(rst), .width_sel(width_sel),
      .carrier_offset_serial_in(co_d), .carrier_offset_word_sync(co_s),
      .sample_offset_serial_in(so_d), .sample_offset_word_sync(so_s),
      .carrier_offset_freq(co_f), .carrier_offset_load(co_ld),
      .sample_offset_freq(so_f), .sample_offset_load(so_ld));
   snl_track_loop i_co (.sys_clk(sys_clk), .ser_data(co_d), .ser_sync(co_s));
   snl_track_loop i_so (.sys_clk(sys_clk), .ser_data(so_d), .ser_sync(so_s));

   // ==========================================
   // clock, load pulse counters, watchdog
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // counting catches extra or missing pulses between checks
   always @(posedge sys_clk) begin
      if (co_ld === 1'b1) co_cnt++;
      if (so_ld === 1'b1) so_cnt++;
   end
   initial begin
      repeat (2000) @(posedge sys_clk);
      miscompares++;
      final_report();
   end

   // ==========================================
   // checking and scenarios
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // both ports at once, one width; words left justified
   task automatic word_pair(input logic [1:0] sel, input int n, input logic [31:0] wc, input logic [31:0] ws);
      int c0, s0;
      width_sel = sel;
      c0 = co_cnt;
      s0 = so_cnt;
      fork
         i_co.send(wc, n);
         i_so.send(ws, n);
      join
      @(negedge sys_clk);
      chk("carrier_load", 32'h1, {31'h0, co_ld});
      chk("sample_load", 32'h1, {31'h0, so_ld});
      chk("carrier_freq", wc << (32 - n), co_f);
      chk("sample_freq", ws << (32 - n), so_f);
      @(negedge sys_clk);
      chk("carrier_loads", c0 + 1, co_cnt);
      chk("sample_loads", s0 + 1, so_cnt);
   endtask : word_pair

   // carrier words back to back, sample port left alone
   task automatic back_to_back;
      int c0, s0;
      logic [31:0] keep;
      width_sel = SNL_WSEL_8;
      c0 = co_cnt;
      s0 = so_cnt;
      keep = so_f;
      i_co.send(32'h0000_003c, 8);
      i_co.send(32'h0000_00d1, 8);
      @(negedge sys_clk);
      @(negedge sys_clk);
      chk("b2b_freq", 32'hd100_0000, co_f);
      chk("b2b_loads", c0 + 2, co_cnt);
      chk("idle_sample_freq", keep, so_f);
      chk("idle_sample_loads", s0, so_cnt);
   endtask : back_to_back

   // sync on the last bit edge of a cut word restarts the port, only the second word loads
   task automatic cut_word;
      int c0;
      width_sel = SNL_WSEL_8;
      c0 = co_cnt;
      i_co.send(32'h0000_0081, 7);
      i_co.send(32'h0000_0066, 8);
      @(negedge sys_clk);
      @(negedge sys_clk);
      chk("cut_freq", 32'h6600_0000, co_f);
      chk("cut_loads", c0 + 1, co_cnt);
   endtask : cut_word

   task automatic final_report;
      if (miscompares == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report

   // ==========================================
   // main sequence
   initial begin
      rst = 1'b1;
      width_sel = SNL_WSEL_32;
      miscompares = 0;
      n_tests = 0;
      co_cnt = 0;
      so_cnt = 0;
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      chk("rst_freq", 32'h0, co_f | so_f);
      chk("rst_load", 32'h0, {30'h0, co_ld, so_ld});
      word_pair(SNL_WSEL_8, 8, 32'ha5c3_9e17, 32'h5a3c_61e8);
      word_pair(SNL_WSEL_16, 16, 32'h1234_8001, 32'hfedc_7ffe);
      word_pair(SNL_WSEL_24, 24, 32'hc0ff_ee81, 32'h3f00_117e);
      word_pair(SNL_WSEL_32, 32, 32'h8000_0001, 32'h7ffe_fffe);
      back_to_back();
      cut_word();
      final_report();
   end
endmodule : tb_top
